// ==== common/ishp_pkg.sv ====
// What this block does
// - Interface-select strap low enables the two-wire port, high enables the four-wire port.
// - Slave only; standard, fast and high-speed rates, first two share one protocol.
// - Answers 7-bit addresses only; never acknowledges 10-bit or general-call addresses.
// - Slave address comes from three strap pins through a fixed eight-entry table.
// - Every transfer starts with SDA falling while SCL is high; slave detects it.
// - Acknowledge a matching address only, SDA low over the ninth clock's high phase.
// - Receiver acknowledges each byte, except a low byte the full write buffer refuses; nine-clock groups repeat as long as master wants.
// - SDA rising while SCL is high ends a transfer and frees the bus.
// - Reset pin low forces every register, power-down included, to its default.
// - After reset registers stay default until host writes the power-down register.
// - Software reset register write restores defaults; four-wire port needs value 6600h.
// - Communication blocked during reset; host waits at least 30 us after software reset.
// - Power-on reset acts exactly like the reset pin.
// - Communication accepted no later than 250 us after any reset release.
// - Direction bit 0 means write to the device, 1 means read from it.
// - Byte 00001xxx is never acknowledged and selects high-rate protocol until stop.
// - Registers are 16 bits, high byte first; a write acts after the low byte.
package ishp_pkg;
    // ------------------------------------------------
    // Timing
    // ------------------------------------------------
    localparam int CLK_MHZ = 10;
    localparam int STARTUP_US = 250;
    localparam int SWRST_US = 30;
    localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ; // Longest time, exactly 2500 cycles at 10 MHz
    localparam int SWRST_CYC = SWRST_US * CLK_MHZ;
    localparam int BLK_W = 12;
    // ------------------------------------------------
    // Register map and framing
    // ------------------------------------------------
    localparam logic [7:0] PD_OFFSET = 8'h6b;
    localparam logic [7:0] SWRST_OFFSET = 8'h7c;
    localparam logic [15:0] PD_RESET = 16'h0000;
    localparam logic [15:0] SWRST_KEY = 16'h6600;
    localparam logic [7:0] HS_MASK = 8'hf8;
    localparam logic [7:0] HS_CODE = 8'h08;
    localparam int BYTE_MSB = 7;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    typedef struct packed {logic [7:0] hi; logic [7:0] lo;} ishp_reg_t;
    typedef struct packed {logic [7:0] addr; ishp_reg_t value;} ishp_word_t;
    typedef struct packed {logic [6:0] addr; logic rw;} ishp_addr_byte_t;
    localparam int WORD_W = $bits(ishp_word_t);
    // Strap order is {strap 2, strap 0, strap 1}
    function automatic logic [6:0] strap_addr(input logic [2:0] s);
        unique case (s)
            3'h0: strap_addr = 7'h61;
            3'h1: strap_addr = 7'h64;
            3'h2: strap_addr = 7'h62;
            3'h3: strap_addr = 7'h65;
            3'h4: strap_addr = 7'h2c;
            3'h5: strap_addr = 7'h2e;
            3'h6: strap_addr = 7'h2d;
            default: strap_addr = 7'h2f;
        endcase
    endfunction : strap_addr
endpackage : ishp_pkg

// ==== common/ishp_word_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface ishp_word_if #(parameter int W = 24);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ishp_word_if
`default_nettype wire

// ==== rtl/ishp_pin_filter.sv ====
`timescale 1ns/1ns
`default_nettype none
module ishp_pin_filter #(
    parameter int N = 2,
    parameter int FILT_LEN = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Pins and filtered levels
    input wire logic [N-1:0] pinIn,
    output logic [N-1:0] pinOut
);
    localparam int CW = $clog2(FILT_LEN + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(FILT_LEN - 1);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] out;
        logic [CW-1:0] cnt;
    } ishp_filt_st_t;
    ishp_filt_st_t st, next_st;

    if (FILT_LEN < 1) begin : g_chk
        $error("Filter length below one");
    end

    // Whole vector moves at once, so SCL and SDA keep their order
    always_comb begin
        next_st = st;
        next_st.s1 = pinIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.cnt = '0;
        if (st.s2 == st.s3 && st.s2 != st.out) begin
            next_st.cnt = st.cnt + 1'b1;
            if (st.cnt == CNT_LAST) begin
                next_st.out = st.s2;
                next_st.cnt = '0;
            end
        end
    end

    // Idle bus reads high
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{s1: '1, s2: '1, s3: '1, out: '1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign pinOut = st.out;

    property p_filter;
        @(posedge ref_clk) disable iff (!nrst)
        !$stable(st.out) |-> $past(st.cnt) == CNT_LAST;
    endproperty
    a_filter: assert property (p_filter) else $error("short pulse passed");
endmodule : ishp_pin_filter
`default_nettype wire

// ==== rtl/ishp_word_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module ishp_word_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Fill and drain sides
    ishp_word_if.snk inp,
    ishp_word_if.src outp
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] rdPtr;
        logic [PW-1:0] wrPtr;
        logic [CW-1:0] count;
    } ishp_fifo_st_t;
    ishp_fifo_st_t st, next_st;
    logic doPush;
    logic doPop;

    if (DEPTH < 2) begin : g_chk
        $error("Depth below two");
    end

    assign inp.ready = st.count != FULL;
    assign outp.valid = st.count != '0;
    assign outp.data = st.mem[st.rdPtr];
    assign doPush = inp.valid & inp.ready;
    assign doPop = outp.valid & outp.ready;

    // Ring pointers wrap explicitly so any depth of two or more works
    always_comb begin
        next_st = st;
        if (doPush) begin
            next_st.mem[st.wrPtr] = inp.data;
            next_st.wrPtr = (st.wrPtr == LAST) ? '0 : st.wrPtr + 1'b1;
        end
        if (doPop) begin
            next_st.rdPtr = (st.rdPtr == LAST) ? '0 : st.rdPtr + 1'b1;
        end
        next_st.count = st.count + CW'(doPush) - CW'(doPop);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    property p_fifo_full;
        @(posedge ref_clk) disable iff (!nrst)
        st.count == FULL && !doPop |=> st.count == FULL && !inp.ready;
    endproperty
    a_fifo_full: assert property (p_fifo_full) else $error("full fifo grew");
endmodule : ishp_word_fifo
`default_nettype wire

// ==== rtl/ishp_i2c_slave.sv ====
`timescale 1ns/1ns
`default_nettype none
module ishp_i2c_slave #(
    parameter int FIFO_DEPTH = 4,
    parameter int FILT_LEN = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Strap pins
    input wire logic ifaceSelect,
    input wire logic addrStrap0,
    input wire logic addrStrap1,
    input wire logic addrStrap2,
    // Two-wire bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Port status
    output logic i2cEnable,
    output logic spiEnable,
    output logic commReady,
    output logic highRateProtocol,
    // Local registers
    output logic [15:0] analogPowerDownControl,
    output logic softResetPulse,
    // Register write port
    output logic regWrValid,
    input wire logic regWrReady,
    output logic [7:0] regWrAddr,
    output logic [15:0] regWrData,
    // Register read port
    output logic [7:0] regRdAddr,
    input wire logic [15:0] regRdData
);
    // ------------------------------------------------
    // Types and constants
    // ------------------------------------------------
    localparam int BW = ishp_pkg::BLK_W;
    localparam int MSB = ishp_pkg::BYTE_MSB;
    localparam logic [BW-1:0] STARTUP_LD = BW'(ishp_pkg::STARTUP_CYC);
    localparam logic [BW-1:0] SWRST_LD = BW'(ishp_pkg::SWRST_CYC);

    typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK, S_SKIP} ishp_state_t;
    typedef enum logic [1:0] {P_ADDR, P_PTR, P_HI, P_LO} ishp_phase_t;

    typedef struct packed {
        ishp_state_t state;
        ishp_phase_t phase;
        logic [3:0] bitCnt;
        logic [7:0] rxSh;
        logic [7:0] txSh;
        logic txLo;
        logic rw;
        logic mAck;
        logic [7:0] ptr;
        logic [7:0] hiByte;
        ishp_pkg::ishp_reg_t rdWord;
        logic sdaDrv;
        logic highRate;
        logic [15:0] pd;
        logic [BW-1:0] blkCnt;
        logic swrst;
        logic i2cEn;
        logic [6:0] slave;
        logic sclQ;
        logic sdaQ;
        logic push;
        ishp_pkg::ishp_word_t wordBuf;
    } ishp_top_st_t;

    // Counter starts full so the port stays deaf after any reset
    localparam ishp_top_st_t RST_ST = '{
        state: S_IDLE,
        phase: P_ADDR,
        pd: ishp_pkg::PD_RESET,
        blkCnt: STARTUP_LD,
        sclQ: 1'b1,
        sdaQ: 1'b1,
        default: '0
    };

    ishp_top_st_t st, next_st;
    logic sclF;
    logic sdaF;
    logic selF;
    logic [2:0] strapF;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    ishp_pkg::ishp_addr_byte_t ab;
    ishp_pkg::ishp_reg_t rdSrc;
    ishp_pkg::ishp_word_t outWord;
    logic pdHit;
    logic swrstHit;

    ishp_word_if #(.W(ishp_pkg::WORD_W)) toFifo ();
    ishp_word_if #(.W(ishp_pkg::WORD_W)) fromFifo ();

    // ------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------
    // Bus lines get the glitch filter
    ishp_pin_filter #(.N(2), .FILT_LEN(FILT_LEN)) u_bus_filter (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pinIn({sclIn, sdaIn}),
        .pinOut({sclF, sdaF})
    );

    // Straps are static, one stable sample is enough
    ishp_pin_filter #(.N(4), .FILT_LEN(1)) u_strap_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pinIn({ifaceSelect, addrStrap2, addrStrap0, addrStrap1}),
        .pinOut({selF, strapF})
    );

    // ------------------------------------------------
    // Write buffer
    // ------------------------------------------------
    // Full buffer makes the low byte go unacknowledged
    ishp_word_fifo #(.W(ishp_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .inp(toFifo),
        .outp(fromFifo)
    );

    // Local registers drain at once, others wait for the register port
    assign outWord = fromFifo.data;
    assign pdHit = outWord.addr == ishp_pkg::PD_OFFSET;
    assign swrstHit = outWord.addr == ishp_pkg::SWRST_OFFSET;
    assign fromFifo.ready = pdHit | swrstHit | regWrReady;
    assign regWrValid = fromFifo.valid & ~pdHit & ~swrstHit;
    assign regWrAddr = outWord.addr;
    assign regWrData = outWord.value;
    assign toFifo.valid = st.push;
    assign toFifo.data = st.wordBuf;

    // ------------------------------------------------
    // Bus events
    // ------------------------------------------------
    assign sclRise = sclF & ~st.sclQ;
    assign sclFall = ~sclF & st.sclQ;
    assign startSeen = ~sdaF & st.sdaQ & sclF & st.sclQ;
    assign stopSeen = sdaF & ~st.sdaQ & sclF & st.sclQ;
    assign ab = st.rxSh;
    assign rdSrc = (st.ptr == ishp_pkg::PD_OFFSET) ? st.pd : regRdData;

    // Loads a byte for sending and puts its first bit on SDA
    function automatic ishp_top_st_t load_byte(input ishp_top_st_t s, input logic [7:0] b);
        ishp_top_st_t r;
        r = s;
        r.state = S_TX;
        r.txSh = b;
        r.bitCnt = '0;
        r.sdaDrv = ~b[MSB];
        return r;
    endfunction : load_byte

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.push = 1'b0;
        next_st.swrst = 1'b0;
        next_st.sclQ = sclF;
        next_st.sdaQ = sdaF;
        next_st.i2cEn = ~selF;
        next_st.slave = ishp_pkg::strap_addr(strapF);
        // Blocking window after reset release or software reset
        if (st.blkCnt != '0) begin
            next_st.blkCnt = st.blkCnt - 1'b1;
        end
        unique case (st.state)
            S_IDLE, S_SKIP: begin
                next_st.sdaDrv = 1'b0;
            end
            S_RX: begin
                if (sclRise) begin
                    next_st.rxSh = {st.rxSh[MSB-1:0], sdaF};
                    next_st.bitCnt = st.bitCnt + 4'h1;
                end else if (sclFall && st.bitCnt == ishp_pkg::BYTE_BITS) begin
                    next_st.bitCnt = '0;
                    next_st.state = S_SKIP;
                    unique case (st.phase)
                        P_ADDR: begin
                            // Master code is never acknowledged
                            if ((st.rxSh & ishp_pkg::HS_MASK) == ishp_pkg::HS_CODE) begin
                                next_st.highRate = 1'b1;
                            end else if (ab.addr == st.slave) begin
                                next_st.state = S_ACK;
                                next_st.sdaDrv = 1'b1;
                                next_st.rw = ab.rw;
                                next_st.phase = ab.rw ? P_ADDR : P_PTR;
                            end
                        end
                        P_PTR: begin
                            next_st.ptr = st.rxSh;
                            next_st.phase = P_HI;
                            next_st.state = S_ACK;
                            next_st.sdaDrv = 1'b1;
                        end
                        P_HI: begin
                            next_st.hiByte = st.rxSh;
                            next_st.phase = P_LO;
                            next_st.state = S_ACK;
                            next_st.sdaDrv = 1'b1;
                        end
                        P_LO: begin
                            // Word is only committed once the low byte is here
                            if (toFifo.ready) begin
                                next_st.push = 1'b1;
                                next_st.wordBuf = '{addr: st.ptr,
                                    value: '{hi: st.hiByte, lo: st.rxSh}};
                                next_st.phase = P_PTR;
                                next_st.state = S_ACK;
                                next_st.sdaDrv = 1'b1;
                            end
                        end
                    endcase
                end
            end
            S_ACK: begin
                // Acknowledge held until the ninth clock falls
                if (sclFall) begin
                    if (st.rw) begin
                        next_st = load_byte(next_st, rdSrc.hi);
                        next_st.rdWord = rdSrc;
                        next_st.txLo = 1'b0;
                    end else begin
                        next_st.state = S_RX;
                        next_st.sdaDrv = 1'b0;
                    end
                end
            end
            S_TX: begin
                // Data changes only while SCL is low
                if (sclFall) begin
                    next_st.bitCnt = st.bitCnt + 4'h1;
                    next_st.txSh = {st.txSh[MSB-1:0], 1'b0};
                    next_st.sdaDrv = ~st.txSh[MSB-1];
                    if (st.bitCnt == ishp_pkg::BYTE_BITS - 4'h1) begin
                        next_st.bitCnt = '0;
                        next_st.sdaDrv = 1'b0;
                        next_st.state = S_TXACK;
                    end
                end
            end
            S_TXACK: begin
                if (sclRise) begin
                    next_st.mAck = ~sdaF;
                end
                // Repeated reads refetch the same register
                if (sclFall) begin
                    if (st.mAck && !st.txLo) begin
                        next_st = load_byte(next_st, st.rdWord.lo);
                        next_st.txLo = 1'b1;
                    end else if (st.mAck) begin
                        next_st = load_byte(next_st, rdSrc.hi);
                        next_st.rdWord = rdSrc;
                        next_st.txLo = 1'b0;
                    end else begin
                        next_st.state = S_SKIP;
                    end
                end
            end
        endcase
        // Start and stop override any byte in flight
        if (startSeen) begin
            next_st.sdaDrv = 1'b0;
            next_st.bitCnt = '0;
            next_st.rw = 1'b0;
            next_st.phase = P_ADDR;
            next_st.state = S_IDLE;
            if (st.i2cEn && st.blkCnt == '0) begin
                next_st.state = S_RX;
            end
        end
        if (stopSeen) begin
            next_st.state = S_IDLE;
            next_st.sdaDrv = 1'b0;
            next_st.highRate = 1'b0;
        end
        // Local register writes from the buffer
        if (fromFifo.valid && pdHit) begin
            next_st.pd = outWord.value;
        end
        // Current byte still finishes; only new starts are refused
        if (fromFifo.valid && swrstHit
            && (st.i2cEn || outWord.value == ishp_pkg::SWRST_KEY)) begin
            next_st.pd = ishp_pkg::PD_RESET;
            next_st.swrst = 1'b1;
            next_st.blkCnt = SWRST_LD;
        end
    end

    // One reset input serves both the pin and power-on reset
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= RST_ST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------
    // Outputs
    // ------------------------------------------------
    assign sdaOut = 1'b0;
    assign sdaOe = st.sdaDrv;
    assign i2cEnable = st.i2cEn;
    assign spiEnable = ~st.i2cEn;
    assign commReady = st.blkCnt == '0;
    assign highRateProtocol = st.highRate;
    assign analogPowerDownControl = st.pd;
    assign softResetPulse = st.swrst;
    assign regRdAddr = st.ptr;

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_start_ok;
        startSeen && st.i2cEn && st.blkCnt == '0;
    endsequence
    sequence s_addr_rx;
        st.state == S_RX && st.phase == P_ADDR && sclFall && st.bitCnt == ishp_pkg::BYTE_BITS;
    endsequence

    property p_start;
        s_start_ok |=> st.state == S_RX && st.phase == P_ADDR && !sdaOe;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_stop;
        stopSeen |=> st.state == S_IDLE && !highRateProtocol && !sdaOe;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not free bus");

    property p_addr_ack;
        s_addr_rx ##0 ab.addr == st.slave |=> st.state == S_ACK && sdaOe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

    property p_foreign;
        st.state == S_ACK && $past(st.state) == S_RX && $past(st.phase) == P_ADDR
            |-> ab.addr == st.slave;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign address acked");

    property p_hs;
        s_addr_rx ##0 (st.rxSh & ishp_pkg::HS_MASK) == ishp_pkg::HS_CODE
            |=> highRateProtocol && !sdaOe ##1 !sdaOe;
    endproperty
    a_hs: assert property (p_hs) else $error("master code mishandled");

    property p_push_lo;
        toFifo.valid |-> $past(st.phase) == P_LO && st.phase == P_PTR;
    endproperty
    a_push_lo: assert property (p_push_lo) else $error("word pushed early");

    property p_swrst;
        softResetPulse |-> analogPowerDownControl == ishp_pkg::PD_RESET
            ##1 st.blkCnt == SWRST_LD - 1'b1 && !commReady;
    endproperty
    a_swrst: assert property (p_swrst) else $error("soft reset incomplete");

    property p_block;
        startSeen && !commReady |=> (st.state == S_IDLE) [*2];
    endproperty
    a_block: assert property (p_block) else $error("start taken while blocked");

    property p_spi;
        spiEnable && st.state == S_IDLE |=> st.state == S_IDLE && !sdaOe;
    endproperty
    a_spi: assert property (p_spi) else $error("two-wire port active");
endmodule : ishp_i2c_slave
`default_nettype wire

// ==== tb/ishp_bus_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module ishp_bus_master (
    // Clock in, open-drain bus levels out
    input wire logic ref_clk,
    input wire logic sdaWire,
    output logic scl = 1'b1,
    output logic sdaLow = 1'b0
);
    // Start (up low) or stop (up high): SDA moves while SCL is high
    task automatic cond(input logic up);
        sdaLow = up;
        repeat (10) @(negedge ref_clk);
        scl = 1'b1;
        repeat (10) @(negedge ref_clk);
        sdaLow = ~up;
        repeat (10) @(negedge ref_clk);
        scl = up;
        repeat (2) @(negedge ref_clk);
    endtask : cond
    // Nine bits, MSB first; SDA moves only with SCL low, so no false start
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            sdaLow = ~d[i];
            repeat (10) @(negedge ref_clk);
            scl = 1'b1;
            repeat (5) @(negedge ref_clk);
            q[i] = sdaWire;
            repeat (5) @(negedge ref_clk);
            scl = 1'b0;
            repeat (2) @(negedge ref_clk);
        end
    endtask : xfer
endmodule : ishp_bus_master
`default_nettype wire

// ==== tb/ishp_i2c_slave_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module ishp_i2c_slave_bench;
    logic ref_clk = 1'b0, nrst = 1'b0, regWrReady = 1'b1;
    logic ifSel = 1'b0, a0 = 1'b0, a1 = 1'b1, a2 = 1'b0;
    logic scl, mLow, sdaOe, i2cEn, spiEn, rdy, hs, wv, srp;
    logic [7:0] wa, ra;
    logic [15:0] pd, wd, rdData = 16'h5aa5;
    logic [8:0] q;
    int n_errors = 0, compares = 0, nSwrst = 0;
    wire logic sdaWire = ~(sdaOe | mLow);
    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;
    ishp_i2c_slave u_dut (.ref_clk(ref_clk), .nrst(nrst), .ifaceSelect(ifSel), .addrStrap0(a0),
        .addrStrap1(a1), .addrStrap2(a2), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(),
        .sdaOe(sdaOe), .i2cEnable(i2cEn), .spiEnable(spiEn), .commReady(rdy),
        .highRateProtocol(hs), .analogPowerDownControl(pd), .softResetPulse(srp),
        .regWrValid(wv), .regWrReady(regWrReady), .regWrAddr(wa), .regWrData(wd),
        .regRdAddr(ra), .regRdData(rdData));
    ishp_bus_master u_m (.ref_clk(ref_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(mLow));
    // Pulse lasts one clock, so exactly one falling edge sees it
    always @(negedge ref_clk) nSwrst += int'(srp === 1'b1);
    task automatic chk(input logic ok, input string m);
        compares++;
        n_errors += int'(!ok);
        if (!ok) $display("mismatch %0t %s", $time, m);
    endtask : chk
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic tx(input logic [7:0] d, input logic ack);
        u_m.xfer({d, 1'b1}, q);
        chk(q[0] === ~ack, "ack");
    endtask : tx
    // High-rate code, general call, foreign address: none acknowledged
    task automatic t_nack();
        logic [7:0] b[3] = '{8'h0a, 8'h00, 8'hca};
        foreach (b[i]) begin
            u_m.cond(1'b0);
            tx(b[i], 1'b0);
            chk(hs === (i == 0), "high rate");
            u_m.cond(1'b1);
        end
    endtask : t_nack
    // Power-down word, live on its low byte, then only its high byte read back
    task automatic t_rw();
        u_m.cond(1'b0);
        tx(8'hc8, 1'b1);
        tx(8'h6b, 1'b1);
        tx(8'h12, 1'b1);
        chk(pd === 16'h0000, "early");
        tx(8'h34, 1'b1);
        chk(pd === 16'h1234, "write");
        u_m.cond(1'b0);
        tx(8'hc9, 1'b1);
        u_m.xfer(9'h1ff, q);
        chk(q[8:1] === 8'h12, "read");
        u_m.cond(1'b1);
        // Outside register: pointer only, then both bytes with master ack between
        u_m.cond(1'b0);
        tx(8'hc8, 1'b1);
        tx(8'h10, 1'b1);
        chk(ra === 8'h10, "pointer");
        u_m.cond(1'b0);
        tx(8'hc9, 1'b1);
        u_m.xfer(9'h1fe, q);
        chk(q[8:1] === rdData[15:8], "read hi");
        u_m.xfer(9'h1ff, q);
        chk(q[8:1] === rdData[7:0], "read lo");
        u_m.cond(1'b1);
    endtask : t_rw
    // Other strap setting, then four-wire select: address and port follow the pins
    task automatic t_strap();
        {a2, a0, a1} = 3'h6;
        repeat (8) @(negedge ref_clk);
        u_m.cond(1'b0);
        tx(8'hc8, 1'b0);
        u_m.cond(1'b1);
        u_m.cond(1'b0);
        tx(8'h5a, 1'b1);
        u_m.cond(1'b1);
        ifSel = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk(spiEn === 1'b1 && i2cEn === 1'b0, "select");
        u_m.cond(1'b0);
        tx(8'h5a, 1'b0);
        u_m.cond(1'b1);
        {ifSel, a2, a0, a1} = 4'h1;
        repeat (8) @(negedge ref_clk);
    endtask : t_strap
    // Stalled sink: four words fit, the fifth low byte is refused
    task automatic t_fifo();
        regWrReady = 1'b0;
        u_m.cond(1'b0);
        tx(8'hc8, 1'b1);
        for (int i = 0; i < 5; i++) begin
            tx(8'h10, 1'b1);
            tx(8'(i), 1'b1);
            tx(8'hc0 | 8'(i), i < 4);
        end
        u_m.cond(1'b1);
        regWrReady = 1'b1;
        // One word leaves per clock, in arrival order
        for (int k = 0; k < 4; k++) begin
            chk(wv === 1'b1 && wa === 8'h10 && wd === {8'(k), 8'hc0 | 8'(k)}, "word");
            @(negedge ref_clk);
        end
        chk(wv === 1'b0, "drain");
    endtask : t_fifo
    // Software reset: defaults back, new starts refused until the block ends
    task automatic t_swrst();
        u_m.cond(1'b0);
        tx(8'hc8, 1'b1);
        tx(8'h7c, 1'b1);
        tx(8'h00, 1'b1);
        tx(8'h01, 1'b1);
        chk(pd === 16'h0000 && rdy === 1'b0 && nSwrst == 1, "soft reset");
        u_m.cond(1'b1);
        u_m.cond(1'b0);
        tx(8'hc8, 1'b0);
        u_m.cond(1'b1);
        for (int i = 0; i < 320 && rdy !== 1'b1; i++) @(negedge ref_clk);
        u_m.cond(1'b0);
        tx(8'hc8, 1'b1);
        tx(8'h6b, 1'b1);
        tx(8'h56, 1'b1);
        tx(8'h78, 1'b1);
        u_m.cond(1'b1);
        chk(pd === 16'h5678 && nSwrst == 1, "after block");
    endtask : t_swrst
    // Reset pin low: defaults forced, port deaf until the startup delay ends
    task automatic t_reset();
        nrst = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(pd === 16'h0000 && rdy === 1'b0 && wv === 1'b0 && hs === 1'b0, "reset");
        nrst = 1'b1;
        for (int i = 0; i < 2520 && rdy !== 1'b1; i++) @(negedge ref_clk);
        chk(rdy === 1'b1 && i2cEn === 1'b1 && spiEn === 1'b0, "startup");
    endtask : t_reset
    // Reset, bounded wait for ready, the scenarios, then a final reset before the summary
    initial begin
        t_reset();
        if (rdy !== 1'b1) summarize();
        t_nack();
        t_rw();
        t_strap();
        t_fifo();
        t_swrst();
        t_reset();
        summarize();
    end
endmodule : ishp_i2c_slave_bench
`default_nettype wire
